// ### design/sdp_consts.svh
// How it works
// - Data read pops the receive FIFO
// - Data write shifts out programmed bit count
// - Low eight bits carry both directions
// - Transmit DMA reads from transmit base
// - Transmit length is eleven-bit count field
// - Receive DMA writes from receive base
// - Receive length is eleven-bit count field
// - Block done sets flag, write-one clears
// - Byte into full FIFO sets error flag
`ifndef SDP_CONSTS_SVH
`define SDP_CONSTS_SVH

// Register offsets
`define SDP_CTRL_ADDR      16'hC0C0
`define SDP_STATUS_ADDR    16'hC0C2
`define SDP_IRQ_CLR_ADDR   16'hC0C4
`define SDP_DATA_ADDR      16'hC0D6
`define SDP_TX_BASE_ADDR   16'hC0D8
`define SDP_TX_LEN_ADDR    16'hC0DA
`define SDP_RX_BASE_ADDR   16'hC0DC
`define SDP_RX_LEN_ADDR    16'hC0DE

// Control fields
`define SDP_CTRL_BITLEN_LSB 0
`define SDP_CTRL_BITLEN_MSB 2
`define SDP_CTRL_RX_READY   3
`define SDP_CTRL_DMA_TX     4
`define SDP_CTRL_DMA_RX     5
`define SDP_CTRL_FIFO_INIT  6
`define SDP_CTRL_RX_FULL    7

// Status fields
`define SDP_STAT_XFER      0
`define SDP_STAT_RX_IRQ    2
`define SDP_STAT_FIFO_ERR  7

// Clear fields
`define SDP_CLR_XFER       0

// Count field width
`define SDP_LEN_MSB        10

// Reset and idle values
`define SDP_WORD_RESET     16'h0000
`define SDP_BYTE_IDLE      8'hFF

// Timing
`define SDP_CLK_NS         50
`define SDP_SCK_HALF_NS    100
`define SDP_SCK_HALF_CYC   (`SDP_SCK_HALF_NS / `SDP_CLK_NS)

// FIFO
`define SDP_FIFO_DEPTH     8

`endif

// ### design/sdp_pkg.sv
package sdp_pkg;
    typedef enum logic [2:0] {
        SDP_IDLE,
        SDP_FETCH,
        SDP_WAIT,
        SDP_LOAD,
        SDP_SHIFT
    } sdp_state_e;

    typedef logic [7:0]  sdp_byte_t;
    typedef logic [15:0] sdp_word_t;
endpackage

// ### design/sdp_rx_fifo.sv
`timescale 1ns/1ps
`include "sdp_consts.svh"
module sdp_rx_fifo
    import sdp_pkg::*;
(
    // Clock and reset
    input  wire logic      clock,
    input  wire logic      rst_n,
    // Control
    input  wire logic      push,
    input  wire logic      pop,
    input  wire logic      flush,
    input  wire sdp_byte_t din,
    // State
    output sdp_byte_t      dout,
    output logic           empty,
    output logic           full
);
    sdp_byte_t  mem [`SDP_FIFO_DEPTH];
    logic [2:0] rd_ptr;
    logic [2:0] wr_ptr;
    logic [3:0] count;
    logic [2:0] next_rd_ptr;
    logic [2:0] next_wr_ptr;
    logic [3:0] next_count;
    logic       do_push;
    logic       do_pop;

    assign dout  = mem[rd_ptr];
    assign empty = (count == 4'h0);
    assign full  = (count == 4'(`SDP_FIFO_DEPTH));

    always_comb begin
        do_push     = push && !full && !flush;
        do_pop      = pop && !empty && !flush;
        next_rd_ptr = rd_ptr + 3'(do_pop);
        next_wr_ptr = wr_ptr + 3'(do_push);
        next_count  = count + 4'(do_push) - 4'(do_pop);
        if (flush) begin
            next_rd_ptr = 3'h0;
            next_wr_ptr = 3'h0;
            next_count  = 4'h0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr <= 3'h0;
            wr_ptr <= 3'h0;
            count  <= 4'h0;
        end else begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            count  <= next_count;
        end
    end

    always_ff @(posedge clock) begin
        if (do_push) begin
            mem[wr_ptr] <= din;
        end
    end
endmodule

// ### design/sdp_top.sv
`timescale 1ns/1ps
`include "sdp_consts.svh"
module sdp_top
    import sdp_pkg::*;
(
    // Clock and reset
    input  wire logic      clock,
    input  wire logic      rst_n,
    // Register port
    input  wire sdp_word_t reg_addr,
    input  wire sdp_word_t reg_wdata,
    input  wire logic      reg_write,
    input  wire logic      reg_read,
    output sdp_word_t      reg_rdata,
    // Memory port for DMA
    output sdp_word_t      mem_addr,
    output sdp_byte_t      mem_wdata,
    output logic           mem_write,
    output logic           mem_read,
    input  wire sdp_byte_t mem_rdata,
    // Serial pins
    output logic           sck,
    output logic           mosi,
    output logic           ss_n,
    input  wire logic      miso
);
    localparam int HALF = `SDP_SCK_HALF_CYC;
    sdp_state_e  state,      next_state;
    sdp_word_t   tx_base,    next_tx_base;
    sdp_word_t   rx_base,    next_rx_base;
    logic [10:0] tx_len,     next_tx_len;
    logic [10:0] rx_len,     next_rx_len;
    logic [2:0]  bit_len,    next_bit_len;
    logic        xfer_flag,  next_xfer_flag;
    logic        fifo_err,   next_fifo_err;
    logic        blk_tx,     next_blk_tx;
    logic        blk_rx,     next_blk_rx;
    sdp_word_t   tx_addr,    next_tx_addr;
    sdp_word_t   rx_addr,    next_rx_addr;
    logic [10:0] remaining,  next_remaining;
    sdp_byte_t   tx_shift,   next_tx_shift;
    sdp_byte_t   rx_shift,   next_rx_shift;
    logic [3:0]  bits_left,  next_bits_left;
    logic [7:0]  div,        next_div;
    sdp_word_t   next_reg_rdata, next_mem_addr;
    sdp_byte_t   next_mem_wdata, fifo_dout;
    logic        next_mem_write, next_mem_read;
    logic        next_sck,       next_mosi,      next_ss_n;
    logic        miso_meta,      miso_s;
    logic        fifo_push,      fifo_pop,       fifo_flush;
    logic        fifo_empty,     fifo_full;
    // Bits per programmed byte, zero means eight
    function automatic logic [3:0] bit_count(input logic [2:0] field);
        bit_count = (field == 3'h0) ? 4'h8 : {1'b0, field};
    endfunction
    // Input synchroniser
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            miso_meta <= 1'b0;
            miso_s    <= 1'b0;
        end else begin
            miso_meta <= miso;
            miso_s    <= miso_meta;
        end
    end
    sdp_rx_fifo u_fifo (
        .clock (clock),
        .rst_n (rst_n),
        .push  (fifo_push),
        .pop   (fifo_pop),
        .flush (fifo_flush),
        .din   (rx_shift),
        .dout  (fifo_dout),
        .empty (fifo_empty),
        .full  (fifo_full)
    );
    always_comb begin
        next_state     = state;
        next_tx_base   = tx_base;
        next_rx_base   = rx_base;
        next_tx_len    = tx_len;
        next_rx_len    = rx_len;
        next_bit_len   = bit_len;
        next_xfer_flag = xfer_flag;
        next_fifo_err  = fifo_err;
        next_blk_tx    = blk_tx;
        next_blk_rx    = blk_rx;
        next_tx_addr   = tx_addr;
        next_rx_addr   = rx_addr;
        next_remaining = remaining;
        next_tx_shift  = tx_shift;
        next_rx_shift  = rx_shift;
        next_bits_left = bits_left;
        next_div       = div;
        next_reg_rdata = `SDP_WORD_RESET;
        next_mem_addr  = mem_addr;
        next_mem_wdata = mem_wdata;
        next_mem_write = 1'b0;
        next_mem_read  = 1'b0;
        next_sck       = sck;
        next_mosi      = mosi;
        next_ss_n      = ss_n;
        fifo_push      = 1'b0;
        fifo_pop       = 1'b0;
        fifo_flush     = 1'b0;

        // Register reads
        if (reg_read) begin
            case (reg_addr)
                `SDP_CTRL_ADDR: begin
                    next_reg_rdata[`SDP_CTRL_BITLEN_MSB:`SDP_CTRL_BITLEN_LSB] = bit_len;
                    next_reg_rdata[`SDP_CTRL_RX_READY] = !fifo_empty;
                    next_reg_rdata[`SDP_CTRL_DMA_TX]   = blk_tx;
                    next_reg_rdata[`SDP_CTRL_DMA_RX]   = blk_rx;
                    next_reg_rdata[`SDP_CTRL_RX_FULL]  = fifo_full;
                end
                `SDP_STATUS_ADDR: begin
                    next_reg_rdata[`SDP_STAT_XFER]     = xfer_flag;
                    next_reg_rdata[`SDP_STAT_RX_IRQ]   = !fifo_empty;
                    next_reg_rdata[`SDP_STAT_FIFO_ERR] = fifo_err;
                end
                `SDP_DATA_ADDR: begin
                    next_reg_rdata[7:0] = fifo_empty ? 8'h00 : fifo_dout;
                    fifo_pop = 1'b1;
                end
                `SDP_TX_BASE_ADDR: next_reg_rdata = tx_base;
                `SDP_TX_LEN_ADDR:  next_reg_rdata[`SDP_LEN_MSB:0] = tx_len;
                `SDP_RX_BASE_ADDR: next_reg_rdata = rx_base;
                `SDP_RX_LEN_ADDR:  next_reg_rdata[`SDP_LEN_MSB:0] = rx_len;
                default:           next_reg_rdata = `SDP_WORD_RESET;
            endcase
        end
        // Register writes
        if (reg_write) begin
            case (reg_addr)
                `SDP_CTRL_ADDR: begin
                    next_bit_len = reg_wdata[`SDP_CTRL_BITLEN_MSB:`SDP_CTRL_BITLEN_LSB];
                    if (reg_wdata[`SDP_CTRL_FIFO_INIT]) begin
                        fifo_flush    = 1'b1;
                        next_fifo_err = 1'b0;
                    end
                end
                `SDP_IRQ_CLR_ADDR:
                    if (reg_wdata[`SDP_CLR_XFER]) next_xfer_flag = 1'b0;
                `SDP_TX_BASE_ADDR: next_tx_base = reg_wdata;
                `SDP_TX_LEN_ADDR:  next_tx_len  = reg_wdata[`SDP_LEN_MSB:0];
                `SDP_RX_BASE_ADDR: next_rx_base = reg_wdata;
                `SDP_RX_LEN_ADDR:  next_rx_len  = reg_wdata[`SDP_LEN_MSB:0];
                default: ;
            endcase
        end
        // Transfer engine
        case (state)
            SDP_IDLE: begin
                next_ss_n = 1'b1;
                next_sck  = 1'b0;
                if (reg_write && reg_addr == `SDP_DATA_ADDR) begin
                    next_tx_shift  = reg_wdata[7:0];
                    next_mosi      = reg_wdata[7];
                    next_bits_left = bit_count(reg_wdata[`SDP_CTRL_BITLEN_MSB:0] & 3'h0 | bit_len);
                    next_rx_shift  = 8'h00;
                    next_div       = 8'h00;
                    next_ss_n      = 1'b0;
                    next_state     = SDP_SHIFT;
                end else if (reg_write && reg_addr == `SDP_CTRL_ADDR) begin
                    if (reg_wdata[`SDP_CTRL_DMA_TX] && tx_len != 11'h000) begin
                        next_blk_tx    = 1'b1;
                        next_blk_rx    = reg_wdata[`SDP_CTRL_DMA_RX];
                        next_tx_addr   = tx_base;
                        next_rx_addr   = rx_base;
                        next_remaining = tx_len;
                        next_state     = SDP_FETCH;
                    end else if (reg_wdata[`SDP_CTRL_DMA_RX] && rx_len != 11'h000) begin
                        next_blk_rx    = 1'b1;
                        next_rx_addr   = rx_base;
                        next_remaining = rx_len;
                        next_state     = SDP_LOAD;
                    end
                end
            end
            SDP_FETCH: begin
                next_mem_addr = tx_addr;
                next_mem_read = 1'b1;
                next_state    = SDP_WAIT;
            end
            SDP_WAIT: next_state = SDP_LOAD;
            SDP_LOAD: begin
                next_tx_shift  = blk_tx ? mem_rdata : `SDP_BYTE_IDLE;
                next_mosi      = next_tx_shift[7];
                next_bits_left = 4'h8;
                next_rx_shift  = 8'h00;
                next_div       = 8'h00;
                next_ss_n      = 1'b0;
                next_state     = SDP_SHIFT;
            end
            SDP_SHIFT: begin
                next_div = div + 8'h01;
                if (div == 8'(HALF - 1)) next_sck = 1'b1;
                // Synced input lags two cycles, so sample in the first cycle of the high phase
                if (div == 8'(HALF)) next_rx_shift = {rx_shift[6:0], miso_s};
                if (div == 8'(2 * HALF - 1)) begin
                    next_sck = 1'b0;
                    next_div = 8'h00;
                    if (bits_left != 4'h1) begin
                        next_bits_left = bits_left - 4'h1;
                        next_tx_shift  = {tx_shift[6:0], 1'b0};
                        next_mosi      = tx_shift[6];
                    end else if (!blk_tx && !blk_rx) begin
                        fifo_push  = 1'b1;
                        next_state = SDP_IDLE;
                        next_ss_n  = 1'b1;
                        if (fifo_full) next_fifo_err = 1'b1;
                    end else begin
                        if (blk_rx) begin
                            next_mem_addr  = rx_addr;
                            next_mem_wdata = rx_shift;
                            next_mem_write = 1'b1;
                            next_rx_addr   = rx_addr + 16'h0001;
                        end
                        next_tx_addr   = tx_addr + 16'h0001;
                        next_remaining = remaining - 11'h001;
                        if (remaining == 11'h001) begin
                            next_xfer_flag = 1'b1;
                            next_blk_tx    = 1'b0;
                            next_blk_rx    = 1'b0;
                            next_ss_n      = 1'b1;
                            next_state     = SDP_IDLE;
                        end else begin
                            next_state = blk_tx ? SDP_FETCH : SDP_LOAD;
                        end
                    end
                end
            end
            default: next_state = SDP_IDLE;
        endcase
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state     <= SDP_IDLE;
            tx_base   <= `SDP_WORD_RESET;
            rx_base   <= `SDP_WORD_RESET;
            tx_len    <= 11'h000;
            rx_len    <= 11'h000;
            bit_len   <= 3'h0;
            xfer_flag <= 1'b0;
            fifo_err  <= 1'b0;
            blk_tx    <= 1'b0;
            blk_rx    <= 1'b0;
            tx_addr   <= `SDP_WORD_RESET;
            rx_addr   <= `SDP_WORD_RESET;
            remaining <= 11'h000;
            tx_shift  <= 8'h00;
            rx_shift  <= 8'h00;
            bits_left <= 4'h0;
            div       <= 8'h00;
            reg_rdata <= `SDP_WORD_RESET;
            mem_addr  <= `SDP_WORD_RESET;
            mem_wdata <= 8'h00;
            mem_write <= 1'b0;
            mem_read  <= 1'b0;
            sck       <= 1'b0;
            mosi      <= 1'b0;
            ss_n      <= 1'b1;
        end else begin
            state     <= next_state;
            tx_base   <= next_tx_base;
            rx_base   <= next_rx_base;
            tx_len    <= next_tx_len;
            rx_len    <= next_rx_len;
            bit_len   <= next_bit_len;
            xfer_flag <= next_xfer_flag;
            fifo_err  <= next_fifo_err;
            blk_tx    <= next_blk_tx;
            blk_rx    <= next_blk_rx;
            tx_addr   <= next_tx_addr;
            rx_addr   <= next_rx_addr;
            remaining <= next_remaining;
            tx_shift  <= next_tx_shift;
            rx_shift  <= next_rx_shift;
            bits_left <= next_bits_left;
            div       <= next_div;
            reg_rdata <= next_reg_rdata;
            mem_addr  <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
            mem_write <= next_mem_write;
            mem_read  <= next_mem_read;
            sck       <= next_sck;
            mosi      <= next_mosi;
            ss_n      <= next_ss_n;
        end
    end
endmodule

// ### dv/sdp_spi_dev.sv
`timescale 1ns/1ps
module sdp_spi_dev
    import sdp_pkg::*;
(
    // Serial pins
    input  wire logic      sck,
    input  wire logic      mosi,
    input  wire logic      ss_n,
    output logic           miso,
    // Byte k of a frame answered as seed xor k
    input  wire sdp_byte_t seed
);
    sdp_byte_t got[$];
    sdp_byte_t tx, sh;
    int        nb, k;

    initial miso = 1'b1;
    // Select starts a frame with the first bit out
    always @(negedge ss_n) begin
        k = 0;
        nb = 0;
        sh = 8'h00;
        tx = seed;
        miso = tx[7];
    end
    // Mode 0: sample on the rising edge, MSB first
    always @(posedge sck) begin
        if (!ss_n) begin
            sh = {sh[6:0], mosi};
            tx = {tx[6:0], 1'b0};
            nb++;
            if (nb == 8) begin
                got.push_back(sh);
                nb = 0;
                k++;
                tx = seed ^ 8'(k);
            end
        end
    end
    // Next bit after the falling edge
    always @(negedge sck) begin
        if (!ss_n)
            miso = tx[7];
    end
    // Partial byte kept right-aligned; released line inverts
    always @(posedge ss_n) begin
        if (nb != 0)
            got.push_back(sh);
        nb = 0;
        miso = ~miso;
    end
endmodule

// ### dv/sdp_top_asserts.sv
`timescale 1ns/1ps
`include "sdp_consts.svh"
module sdp_top_asserts
    import sdp_pkg::*;
(
    // Clock and reset
    input wire logic      clock,
    input wire logic      rst_n,
    // Register port
    input wire sdp_word_t reg_addr,
    input wire sdp_word_t reg_wdata,
    input wire logic      reg_write,
    input wire logic      reg_read,
    input wire sdp_word_t reg_rdata,
    // Memory and serial
    input wire sdp_word_t mem_addr,
    input wire logic      mem_write,
    input wire logic      mem_read,
    input wire logic      sck,
    input wire logic      mosi,
    input wire logic      ss_n
);
    typedef struct packed {
        logic [2:0] len;
        logic [3:0] cnt;
        logic       pio, wf, pss, psck;
        sdp_word_t  txb, rxb, lrd, lwr;
    } sdp_chk_s;
    sdp_chk_s h, next_h;

    // Shadows of bit length, bases and last DMA addresses
    always_comb begin
        next_h = h;
        next_h.pss = ss_n;
        next_h.psck = sck;
        next_h.cnt = (h.pss && !ss_n) ? 4'h0 : h.cnt + 4'(sck && !h.psck);
        next_h.wf = (h.pss && !ss_n) || (h.wf && !mem_write);
        if (mem_read)
            next_h.lrd = mem_addr;
        if (mem_write)
            next_h.lwr = mem_addr;
        if (reg_write && reg_addr == `SDP_CTRL_ADDR) begin
            next_h.len = reg_wdata[2:0];
            next_h.pio = 1'b0;
        end
        if (reg_write && reg_addr == `SDP_DATA_ADDR)
            next_h.pio = 1'b1;
        if (reg_write && reg_addr == `SDP_TX_BASE_ADDR)
            next_h.txb = reg_wdata;
        if (reg_write && reg_addr == `SDP_RX_BASE_ADDR)
            next_h.rxb = reg_wdata;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            h <= '0;
        else
            h <= next_h;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_data_upper;
        $past(reg_read) && $past(reg_addr) == `SDP_DATA_ADDR |-> reg_rdata[15:8] == 8'h00;
    endproperty
    a_data_upper: assert property (p_data_upper) else $error("data upper bits set");
    property p_pio_bits;
        $rose(ss_n) && h.pio |-> h.cnt == ((h.len == 3'h0) ? 4'h8 : {1'b0, h.len});
    endproperty
    a_pio_bits: assert property (p_pio_bits) else $error("wrong bit count");
    property p_sck_high;
        $rose(sck) |=> sck ##1 !sck;
    endproperty
    a_sck_high: assert property (p_sck_high) else $error("clock high time");
    property p_mosi_hold;
        sck && $past(sck) |-> $stable(mosi);
    endproperty
    a_mosi_hold: assert property (p_mosi_hold) else $error("data moved while clock high");
    property p_tx_base;
        mem_read && ss_n |-> mem_addr == h.txb;
    endproperty
    a_tx_base: assert property (p_tx_base) else $error("first fetch not at base");
    property p_rd_step;
        mem_read && !ss_n |-> mem_addr == h.lrd + 16'h0001;
    endproperty
    a_rd_step: assert property (p_rd_step) else $error("fetch not consecutive");
    property p_rx_base;
        mem_write && h.wf |-> mem_addr == h.rxb;
    endproperty
    a_rx_base: assert property (p_rx_base) else $error("first store not at base");
    property p_wr_step;
        mem_write && !h.wf |-> mem_addr == h.lwr + 16'h0001;
    endproperty
    a_wr_step: assert property (p_wr_step) else $error("store not consecutive");
endmodule

bind sdp_top sdp_top_asserts u_chk (
    .clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .mem_addr, .mem_write, .mem_read, .sck, .mosi, .ss_n
);

// ### dv/tb_sdp_top.sv
`timescale 1ns/1ps
`include "sdp_consts.svh"
module tb_sdp_top
    import sdp_pkg::*;
;
    logic        clock, rst_n, reg_write, reg_read, sck, mosi, ss_n, miso, mem_write, mem_read;
    sdp_word_t   reg_addr, reg_wdata, reg_rdata, mem_addr, rv, w, b;
    sdp_byte_t   mem_wdata, mem_rdata, seed;
    sdp_byte_t   mem [0:65535];
    logic [31:0] rs;
    int          n_fail, n_tests, i, j, n;

    sdp_top DUT (
        .clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .mem_addr,
        .mem_wdata, .mem_write, .mem_read, .mem_rdata, .sck, .mosi, .ss_n, .miso
    );
    sdp_spi_dev u_dev (.sck, .mosi, .ss_n, .miso, .seed);

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Memory answers the cycle after a read, else a changing value
    always @(posedge clock) begin
        if (mem_write)
            mem[mem_addr] <= mem_wdata;
        mem_rdata <= mem_read ? mem[mem_addr] : ~mem_rdata;
    end

    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic check(input string nm, input sdp_word_t got, input sdp_word_t exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input sdp_word_t a, input sdp_word_t v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input sdp_word_t a);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask
    task automatic frame();
        for (int k = 0; k < 9 && ss_n; k++) @(posedge clock);
        for (int k = 0; k < 9000 && !ss_n; k++) @(posedge clock);
        repeat (3) @(posedge clock);
    endtask
    task automatic pio(input int nb, input sdp_byte_t v);
        wr(`SDP_CTRL_ADDR, 16'(nb % 8));
        wr(`SDP_DATA_ADDR, {8'h00, v});
        frame();
        check("sent", {8'h00, u_dev.got.pop_back()}, {8'h00, v >> (8 - nb)});
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        {reg_write, reg_read, reg_addr, reg_wdata, mem_rdata, seed} = '0;
        rs = 32'hB044;
        n_fail = 0;
        n_tests = 0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        // Reset values, then one unmapped place
        for (j = 0; j < 5; j++) begin
            rd(16'hC0D8 + 16'(2 * j));
            check("reset", rv, 16'h0000);
        end
        for (j = 0; j < 4; j++) begin
            w = j[0] ? 16'(xs()) & 16'h07FF : 16'(xs());
            wr(16'hC0D8 + 16'(2 * j), w);
            rd(16'hC0D8 + 16'(2 * j));
            check("reg", rv, w);
        end
        // Every bit length, read back and pop
        for (j = 1; j <= 8; j++) begin
            seed = 8'(xs());
            pio(j, 8'(xs()));
            rd(`SDP_STATUS_ADDR);
            check("ready", rv & 16'h0004, 16'h0004);
            rd(`SDP_CTRL_ADDR);
            check("rdy", rv & 16'h0008, 16'h0008);
            rd(`SDP_DATA_ADDR);
            check("data", rv, {8'h00, seed >> (8 - j)});
            rd(`SDP_STATUS_ADDR);
            check("empty", rv & 16'h0004, 16'h0000);
        end
        // Nine bytes into eight places
        for (j = 0; j < 9; j++) begin
            seed = 8'(j * 16 + 3);
            pio(8, 8'(xs()));
        end
        rd(`SDP_CTRL_ADDR);
        check("full", rv & 16'h0080, 16'h0080);
        rd(`SDP_STATUS_ADDR);
        check("ovf", rv & 16'h0080, 16'h0080);
        for (j = 0; j < 9; j++) begin
            rd(`SDP_DATA_ADDR);
            check("fifo", rv, j < 8 ? 16'(j * 16 + 3) : 16'h0000);
        end
        wr(`SDP_CTRL_ADDR, 16'h0040);
        rd(`SDP_STATUS_ADDR);
        check("init", rv & 16'h0080, 16'h0000);
        // Blocks: single byte, random length, receive only, transmit only
        for (j = 0; j < 4; j++) begin
            n = j == 0 ? 1 : 1 + int'(xs() % 6);
            b = 16'(xs());
            seed = 8'(xs());
            for (i = 0; i < n; i++) begin
                mem[b + 16'(i)] = 8'(xs());
                mem[b + 16'h0100 + 16'(i)] = 8'hA5;
            end
            mem[b + 16'h0100 + 16'(n)] = 8'h5A;
            wr(`SDP_TX_BASE_ADDR, b);
            wr(`SDP_TX_LEN_ADDR, 16'(j == 2 ? n + 2 : n));
            wr(`SDP_RX_BASE_ADDR, b + 16'h0100);
            wr(`SDP_RX_LEN_ADDR, 16'(n));
            u_dev.got.delete();
            wr(`SDP_CTRL_ADDR, j == 2 ? 16'h0020 : j == 3 ? 16'h0010 : 16'h0030);
            frame();
            for (i = 0; i < n; i++) begin
                w = {8'h00, j == 2 ? 8'hFF : mem[b + 16'(i)]};
                check("tx", {8'h00, u_dev.got[i]}, w);
                w = {8'h00, j == 3 ? 8'hA5 : seed ^ 8'(i)};
                check("rx", {8'h00, mem[b + 16'h0100 + 16'(i)]}, w);
            end
            check("count", 16'(u_dev.got.size()), 16'(n));
            check("stop", {8'h00, mem[b + 16'h0100 + 16'(n)]}, 16'h005A);
            rd(`SDP_STATUS_ADDR);
            check("done", rv & 16'h0001, 16'h0001);
            wr(`SDP_IRQ_CLR_ADDR, 16'h0001);
            rd(`SDP_STATUS_ADDR);
            check("clear", rv & 16'h0001, 16'h0000);
        end
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        complete_run();
    end
endmodule
